/* File: hw/sgc_global_regs.sv */
// Global control register bank of the switch with Wishbone access

module sgc_global_regs #(
    parameter int STORM_PERIOD_CYC = sgc_pkg::STORM_100_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic size_check_strap_pin_i,
    input wire logic duplex_strap_pin_i,
    input wire logic flow_ctl_strap_pin_i,
    input wire logic speed_strap_pin_i,
    input wire logic len_valid_i,
    input wire logic [10:0] len_i,
    input wire logic tagged_i,
    input wire logic special_cpu_tag_i,
    output logic len_drop_o,
    output logic len_done_o,
    output logic [5:0] reserve_bufs_o,
    input wire logic pick_i,
    input wire logic hi_pend_i,
    input wire logic lo_pend_i,
    output logic serve_hi_o,
    output logic serve_lo_o,
    input wire logic igmp_frame_i,
    output logic igmp_to_switch_port_o,
    output logic vlan_en_o,
    output logic direct_mode_o,
    output logic pretag_en_o,
    input wire logic [11:0] vid_i,
    input wire logic [11:0] port_vid_i,
    output logic [11:0] vid_o,
    output logic [4:0] tag_port_mask_o,
    output logic tag_mask_valid_o,
    input wire logic src_match_i,
    input wire logic dst_match_i,
    output logic mirror_o,
    output logic back_pressure_o,
    output logic half_duplex_o,
    output logic flow_ctl_o,
    output logic speed_10_o,
    input wire logic [4:0] port_is_10_i,
    input wire logic [4:0] bcast_block_i,
    output logic [4:0] storm_block_o
);
    localparam int NP = sgc_pkg::NUM_PORTS;

    logic [7:0] frame_limits;
    logic [7:0] queue_select;
    logic [7:0] switch_port;
    logic [7:0] storm_low;
    logic [3:0] strap_meta;
    logic [3:0] strap_sync;
    logic strap_load;
    logic [5:0] idx;
    logic req;
    logic wr;
    logic [7:0] next_rdata;
    logic [10:0] threshold;
    logic [10:0] limit;
    logic [3:0] ratio;
    logic [3:0] hi_run;
    logic [31:0] fast_cnt;
    logic [3:0] slow_cnt;
    logic fast_tick;
    logic slow_tick;
    logic [10:0] storm_cnt [NP];

    assign idx = wb_adr_i[7:2];
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign threshold = {switch_port[sgc_pkg::SP_STORM_HI:0], storm_low};

    // Straps cross in from pins through two flops before use
    always_ff @(posedge clk_i) begin
        strap_meta <= {size_check_strap_pin_i, duplex_strap_pin_i,
                       flow_ctl_strap_pin_i, speed_strap_pin_i};
        strap_sync <= strap_meta;
    end

    // Strap load happens once, on the first edge after reset release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_load <= 1'b1;
        end else begin
            strap_load <= 1'b0;
        end
    end

    // Frame limits register; strap wins over a write in its cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_limits <= sgc_pkg::FRAME_LIMITS_RST;
        end else if (strap_load) begin
            frame_limits[sgc_pkg::FL_SIZE_DIS] <= strap_sync[3];
        end else if (wr && idx == sgc_pkg::IDX_FRAME_LIMITS) begin
            frame_limits <= wb_dat_i[7:0];
        end
    end

    // Queue select register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            queue_select <= sgc_pkg::QUEUE_SELECT_RST;
        end else if (wr && idx == sgc_pkg::IDX_QUEUE_SELECT) begin
            queue_select <= wb_dat_i[7:0];
        end
    end

    // Switch port register; three strap bits load after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            switch_port <= sgc_pkg::SWITCH_PORT_RST;
        end else if (strap_load) begin
            switch_port[sgc_pkg::SP_HALF] <= strap_sync[2];
            switch_port[sgc_pkg::SP_FC] <= strap_sync[1];
            switch_port[sgc_pkg::SP_10] <= strap_sync[0];
        end else if (wr && idx == sgc_pkg::IDX_SWITCH_PORT) begin
            switch_port <= wb_dat_i[7:0];
        end
    end

    // Low byte of the storm threshold
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            storm_low <= sgc_pkg::STORM_LOW_RST;
        end else if (wr && idx == sgc_pkg::IDX_STORM_LOW) begin
            storm_low <= wb_dat_i[7:0];
        end
    end

    // Read mux; unmapped indices read zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (idx)
            sgc_pkg::IDX_FRAME_LIMITS: next_rdata = frame_limits;
            sgc_pkg::IDX_QUEUE_SELECT: next_rdata = queue_select;
            sgc_pkg::IDX_SWITCH_PORT: next_rdata = switch_port;
            sgc_pkg::IDX_STORM_LOW: next_rdata = storm_low;
            sgc_pkg::IDX_STATUS: next_rdata = {3'h0, storm_block_o};
            default: next_rdata = 8'h00;
        endcase
    end

    // Every access is acked one cycle after it is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            if (req) begin
                wb_dat_o <= {24'h000000, next_rdata};
            end
        end
    end

    // Length limit: huge beats size check, which beats tag limits
    always_comb begin
        if (frame_limits[sgc_pkg::FL_HUGE]) begin
            limit = sgc_pkg::LEN_HUGE;
        end else if (frame_limits[sgc_pkg::FL_SIZE_DIS]) begin
            limit = sgc_pkg::LEN_LEGAL;
        end else if (tagged_i && special_cpu_tag_i) begin
            limit = sgc_pkg::LEN_LEGAL;
        end else if (tagged_i) begin
            limit = sgc_pkg::LEN_TAGGED;
        end else begin
            limit = sgc_pkg::LEN_UNTAGGED;
        end
    end

    // Drop verdict one cycle after the length is offered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            len_drop_o <= 1'b0;
            len_done_o <= 1'b0;
        end else begin
            len_done_o <= len_valid_i;
            len_drop_o <= len_valid_i && (len_i > limit);
        end
    end

    // Reserved high-priority buffers per output queue
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reserve_bufs_o <= 6'h00;
        end else if (frame_limits[sgc_pkg::FL_BUF_RES]) begin
            reserve_bufs_o <= sgc_pkg::BUF_RESERVE;
        end else begin
            reserve_bufs_o <= 6'h00;
        end
    end

    // Ratio from the priority scheme code; zero means strict
    always_comb begin
        unique case (queue_select[sgc_pkg::QS_PRIO_HI:sgc_pkg::QS_PRIO_LO])
            2'b00: ratio = 4'h0;
            2'b01: ratio = sgc_pkg::RATIO_10;
            2'b10: ratio = sgc_pkg::RATIO_5;
            2'b11: ratio = sgc_pkg::RATIO_2;
        endcase
    end

    // Egress picker: after ratio highs a waiting low gets one slot
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serve_hi_o <= 1'b0;
            serve_lo_o <= 1'b0;
            hi_run <= 4'h0;
        end else begin
            serve_hi_o <= 1'b0;
            serve_lo_o <= 1'b0;
            if (pick_i && hi_pend_i &&
                (ratio == 4'h0 || !lo_pend_i || hi_run < ratio)) begin
                serve_hi_o <= 1'b1;
                if (hi_run != 4'hF) begin
                    hi_run <= hi_run + 4'h1;
                end
            end else if (pick_i && lo_pend_i) begin
                serve_lo_o <= 1'b1;
                hi_run <= 4'h0;
            end
        end
    end

    // Frame steering decisions, registered toward the datapath
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            igmp_to_switch_port_o <= 1'b0;
            mirror_o <= 1'b0;
            tag_port_mask_o <= 5'h00;
            tag_mask_valid_o <= 1'b0;
            vid_o <= 12'h000;
        end else begin
            igmp_to_switch_port_o <= igmp_frame_i &&
                queue_select[sgc_pkg::QS_IGMP];
            mirror_o <= queue_select[sgc_pkg::QS_SNIFF] ?
                (src_match_i && dst_match_i) :
                (src_match_i || dst_match_i);
            tag_mask_valid_o <= queue_select[sgc_pkg::QS_TAG_MASK];
            tag_port_mask_o <= queue_select[sgc_pkg::QS_TAG_MASK] ?
                vid_i[4:0] : 5'h00;
            vid_o <= (switch_port[sgc_pkg::SP_NULL_VID] &&
                vid_i == 12'h000) ? port_vid_i : vid_i;
        end
    end

    // Mode levels; the datapath reads these, not the raw registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vlan_en_o <= 1'b0;
            direct_mode_o <= 1'b0;
            pretag_en_o <= 1'b0;
            back_pressure_o <= 1'b0;
            half_duplex_o <= 1'b0;
            flow_ctl_o <= 1'b0;
            speed_10_o <= 1'b0;
        end else begin
            vlan_en_o <= queue_select[sgc_pkg::QS_VLAN];
            direct_mode_o <= queue_select[sgc_pkg::QS_DIRECT];
            pretag_en_o <= queue_select[sgc_pkg::QS_PRETAG];
            back_pressure_o <= switch_port[sgc_pkg::SP_BP];
            half_duplex_o <= switch_port[sgc_pkg::SP_HALF];
            flow_ctl_o <= switch_port[sgc_pkg::SP_FC];
            speed_10_o <= switch_port[sgc_pkg::SP_10];
        end
    end

    // Period timers: slow period is ten fast periods, so they align
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_cnt <= 32'h00000000;
            slow_cnt <= 4'h0;
            fast_tick <= 1'b0;
            slow_tick <= 1'b0;
        end else begin
            fast_tick <= 1'b0;
            slow_tick <= 1'b0;
            if (fast_cnt == 32'(STORM_PERIOD_CYC - 1)) begin
                fast_cnt <= 32'h00000000;
                fast_tick <= 1'b1;
                if (slow_cnt == sgc_pkg::STORM_SLOW_RATIO - 4'h1) begin
                    slow_cnt <= 4'h0;
                    slow_tick <= 1'b1;
                end else begin
                    slow_cnt <= slow_cnt + 4'h1;
                end
            end else begin
                fast_cnt <= fast_cnt + 32'h00000001;
            end
        end
    end

    // Per-port block counters; block once threshold blocks are used
    for (genvar p = 0; p < NP; p++) begin : g_storm
        logic tick;
        assign tick = port_is_10_i[p] ? slow_tick : fast_tick;
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                storm_cnt[p] <= 11'h000;
                storm_block_o[p] <= 1'b0;
            end else if (tick) begin
                storm_cnt[p] <= 11'h000;
                storm_block_o[p] <= 1'b0;
            end else begin
                if (bcast_block_i[p] && storm_cnt[p] != 11'h7FF) begin
                    storm_cnt[p] <= storm_cnt[p] + 11'h001;
                end
                storm_block_o[p] <= (storm_cnt[p] +
                    {10'h000, bcast_block_i[p]}) >= threshold;
            end
        end
    end

    // Bus answers exactly one cycle after the request
    a_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("ack missing after request");

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    // Only the two size bits matter; the upper stored bits are free
    a_len_untagged: assert property (@(posedge clk_i)
        disable iff (rst_i) (len_valid_i && !tagged_i && len_i == 11'h5EF
        && frame_limits[sgc_pkg::FL_HUGE:sgc_pkg::FL_SIZE_DIS] == 2'b00)
        |=> len_drop_o) else $error("1519 byte untagged frame kept");

    a_len_legal: assert property (@(posedge clk_i)
        disable iff (rst_i) (len_valid_i && len_i == sgc_pkg::LEN_LEGAL &&
         frame_limits[sgc_pkg::FL_SIZE_DIS]) |=> !len_drop_o)
        else $error("1536 byte frame dropped");

    a_len_huge: assert property (@(posedge clk_i)
        disable iff (rst_i) (len_valid_i && len_i > sgc_pkg::LEN_HUGE)
        |=> len_drop_o) else $error("oversize frame kept");

    a_buf_reserve: assert property (@(posedge clk_i)
        disable iff (rst_i) $rose(frame_limits[sgc_pkg::FL_BUF_RES]) |=>
        reserve_bufs_o == sgc_pkg::BUF_RESERVE)
        else $error("reserve count wrong");

    a_sniff_and: assert property (@(posedge clk_i)
        disable iff (rst_i) (queue_select[sgc_pkg::QS_SNIFF] &&
        src_match_i && !dst_match_i) |=> !mirror_o)
        else $error("AND sniff mirrored one side");

    a_strict_prio: assert property (@(posedge clk_i)
        disable iff (rst_i) (ratio == 4'h0 && pick_i && hi_pend_i) |=>
        (serve_hi_o && !serve_lo_o))
        else $error("strict mode served low");

    a_speed_follow: assert property (@(posedge clk_i)
        disable iff (rst_i) ##2 speed_10_o ==
        $past(switch_port[sgc_pkg::SP_10])) else $error("speed output stale");

    a_storm_clear: assert property (@(posedge clk_i)
        disable iff (rst_i) fast_tick && !port_is_10_i[0] |=>
        !storm_block_o[0]) else $error("storm block survived period");
endmodule

/* File: hw/sgc_pkg.sv */
// Constants for the switch global control register bank
package sgc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_FRAME_LIMITS = 6'h04;
    localparam logic [5:0] IDX_QUEUE_SELECT = 6'h05;
    localparam logic [5:0] IDX_SWITCH_PORT = 6'h06;
    localparam logic [5:0] IDX_STORM_LOW = 6'h07;
    localparam logic [5:0] IDX_STATUS = 6'h0F;

    // Frame limits register fields
    localparam int FL_HUGE = 2;
    localparam int FL_SIZE_DIS = 1;
    localparam int FL_BUF_RES = 0;
    // Queue select register fields
    localparam int QS_VLAN = 7;
    localparam int QS_IGMP = 6;
    localparam int QS_DIRECT = 5;
    localparam int QS_PRETAG = 4;
    localparam int QS_PRIO_HI = 3;
    localparam int QS_PRIO_LO = 2;
    localparam int QS_TAG_MASK = 1;
    localparam int QS_SNIFF = 0;
    // Switch port register fields
    localparam int SP_BP = 7;
    localparam int SP_HALF = 6;
    localparam int SP_FC = 5;
    localparam int SP_10 = 4;
    localparam int SP_NULL_VID = 3;
    localparam int SP_STORM_HI = 2;

    // Reset values of the stored bits (strap bits load separately)
    localparam logic [7:0] FRAME_LIMITS_RST = 8'hF0;
    localparam logic [7:0] QUEUE_SELECT_RST = 8'h00;
    localparam logic [7:0] SWITCH_PORT_RST = 8'h00;
    localparam logic [7:0] STORM_LOW_RST = 8'h4A;

    // Frame length limits in bytes
    localparam logic [10:0] LEN_UNTAGGED = 11'h5EE;
    localparam logic [10:0] LEN_TAGGED = 11'h5F2;
    localparam logic [10:0] LEN_LEGAL = 11'h600;
    localparam logic [10:0] LEN_HUGE = 11'h77C;

    // Buffers reserved per output queue for high priority
    localparam logic [5:0] BUF_RESERVE = 6'h30;

    // High to low service ratios of the priority scheme codes
    localparam logic [3:0] RATIO_10 = 4'hA;
    localparam logic [3:0] RATIO_5 = 4'h5;
    localparam logic [3:0] RATIO_2 = 4'h2;

    // Storm measurement periods
    localparam int CLK_HZ = 40000000;
    localparam int STORM_100_MS = 50;
    localparam int STORM_10_MS = 500;
    localparam int STORM_100_CYC = CLK_HZ / 1000 * STORM_100_MS;
    localparam logic [3:0] STORM_SLOW_RATIO =
        4'(STORM_10_MS / STORM_100_MS);
    localparam int NUM_PORTS = 5;
endpackage

/* File: bench/sgc_mac_model.sv */
// Far-side MAC model: levels it leaves on the strap pins at reset
module sgc_mac_model (
    input wire logic [3:0] pull_up_i,
    output logic size_check_strap_pin_o,
    output logic duplex_strap_pin_o,
    output logic flow_ctl_strap_pin_o,
    output logic speed_strap_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Unfitted pull-ups leave the internal pull-downs in charge
    assign size_check_strap_pin_o = pull_up_i[0];
    assign duplex_strap_pin_o = pull_up_i[1];
    assign flow_ctl_strap_pin_o = pull_up_i[2];
    assign speed_strap_pin_o = pull_up_i[3];
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the switch global control register bank
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER = 20;
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0, pull_up = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, size_check_strap_pin_i, duplex_strap_pin_i;
    logic flow_ctl_strap_pin_i, speed_strap_pin_i;
    logic len_valid_i = 1'b0, tagged_i = 1'b0, special_cpu_tag_i = 1'b0;
    logic [10:0] len_i = 11'h000;
    logic pick_i = 1'b0, hi_pend_i = 1'b0, lo_pend_i = 1'b0;
    logic igmp_frame_i = 1'b0, src_match_i = 1'b0, dst_match_i = 1'b0;
    logic [11:0] vid_i = 12'h000, port_vid_i = 12'h000, vid_o;
    logic [4:0] port_is_10_i = 5'h00, bcast_block_i = 5'h00;
    logic len_drop_o, len_done_o, serve_hi_o, serve_lo_o, mirror_o;
    logic igmp_to_switch_port_o, vlan_en_o, direct_mode_o, pretag_en_o;
    logic tag_mask_valid_o, back_pressure_o, half_duplex_o;
    logic flow_ctl_o, speed_10_o;
    logic [5:0] reserve_bufs_o;
    logic [4:0] tag_port_mask_o, storm_block_o;
    int fails = 0, samples_checked = 0, cycles = 0;
    int ratio[4] = '{0, 10, 5, 2};

    sgc_global_regs #(.STORM_PERIOD_CYC(PER)) dut (.clk_i, .rst_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .size_check_strap_pin_i, .duplex_strap_pin_i,
        .flow_ctl_strap_pin_i, .speed_strap_pin_i, .len_valid_i, .len_i,
        .tagged_i, .special_cpu_tag_i, .len_drop_o, .len_done_o,
        .reserve_bufs_o, .pick_i, .hi_pend_i, .lo_pend_i, .serve_hi_o,
        .serve_lo_o, .igmp_frame_i, .igmp_to_switch_port_o, .vlan_en_o,
        .direct_mode_o, .pretag_en_o, .vid_i, .port_vid_i, .vid_o,
        .tag_port_mask_o, .tag_mask_valid_o, .src_match_i, .dst_match_i,
        .mirror_o, .back_pressure_o, .half_duplex_o, .flow_ctl_o,
        .speed_10_o, .port_is_10_i, .bcast_block_i, .storm_block_o);
    sgc_mac_model mac (.pull_up_i(pull_up),
        .size_check_strap_pin_o(size_check_strap_pin_i),
        .duplex_strap_pin_o(duplex_strap_pin_i),
        .flow_ctl_strap_pin_o(flow_ctl_strap_pin_i),
        .speed_strap_pin_o(speed_strap_pin_i));

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    // Hang guard; the whole run needs well under two thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [11:0] s, input logic [11:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("FAIL t=%0t seen %h expected %h", $time, s, e);
        end
    endtask

    // Classic cycle: hold everything until ack is seen at a rising edge
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [7:0] d, input logic [3:0] s,
                      output logic [7:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h000000, d};
        // Ack is read before this edge's updates land, so the data
        // taken here is what stood while ack was high; only the hang
        // guard ends a wait that never gets its answer
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(a, 1'b1, d, 4'hF, q);
        repeat (3) @(negedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(a, 1'b0, 8'h00, 4'hF, q);
        chk(12'(q), 12'(e));
    endtask

    // One length query; answer lands one cycle after it is taken
    task automatic len(input logic [10:0] n, input logic t,
                       input logic c, input logic d);
        @(posedge clk_i);
        len_valid_i <= 1'b1;
        len_i <= n;
        tagged_i <= t;
        special_cpu_tag_i <= c;
        @(posedge clk_i);
        len_valid_i <= 1'b0;
        @(negedge clk_i);
        chk(12'({len_done_o, len_drop_o}), 12'({1'b1, d}));
    endtask

    task automatic pick(input logic h, input logic l, input logic [1:0] e);
        @(posedge clk_i);
        pick_i <= 1'b1;
        hi_pend_i <= h;
        lo_pend_i <= l;
        @(posedge clk_i);
        pick_i <= 1'b0;
        @(negedge clk_i);
        chk(12'({serve_hi_o, serve_lo_o}), 12'(e));
    endtask

    task automatic wait_lvl(input int p, input logic v, inout int n);
        int k;
        k = 0;
        while (storm_block_o[p] !== v && k < 2500) begin
            @(negedge clk_i);
            k++;
            n++;
        end
    endtask

    // Fall-to-fall spacing of a block flag equals the storm period
    task automatic gap(input int p, output int n);
        n = 0;
        wait_lvl(p, 1'b1, n);
        wait_lvl(p, 1'b0, n);
        n = 0;
        wait_lvl(p, 1'b1, n);
        wait_lvl(p, 1'b0, n);
    endtask

    task automatic do_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // Main sequence
    initial begin
        int n;
        logic [7:0] q;
        do_reset();
        rd(8'h10, sgc_pkg::FRAME_LIMITS_RST);
        rd(8'h14, 8'h00);
        rd(8'h18, 8'h00);
        rd(8'h1C, 8'h4A);
        wr(8'h20, 8'h55);
        rd(8'h20, 8'h00);
        chk(12'(reserve_bufs_o), 12'h000);
        $display("test reset done");
        len(11'h5EE, 1'b0, 1'b0, 1'b0);
        len(11'h5EF, 1'b0, 1'b0, 1'b1);
        len(11'h5F2, 1'b1, 1'b0, 1'b0);
        len(11'h5F3, 1'b1, 1'b0, 1'b1);
        len(11'h5F3, 1'b1, 1'b1, 1'b0);
        wr(8'h10, 8'hF2);
        len(11'h600, 1'b1, 1'b0, 1'b0);
        len(11'h601, 1'b0, 1'b0, 1'b1);
        // Reserve goes on with huge frames, priority queues follow
        wr(8'h10, 8'hF7);
        len(11'h77C, 1'b0, 1'b0, 1'b0);
        len(11'h77D, 1'b1, 1'b0, 1'b1);
        chk(12'(reserve_bufs_o), 12'h030);
        wb(8'h10, 1'b1, 8'h00, 4'hE, q);
        rd(8'h10, 8'hF7);
        $display("test frame limits done");
        // Mode bits first, VLAN last once the table is in place
        wr(8'h14, 8'h72);
        wr(8'h14, 8'hF2);
        @(posedge clk_i);
        igmp_frame_i <= 1'b1;
        vid_i <= 12'h015;
        src_match_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        chk(12'({vlan_en_o, direct_mode_o, pretag_en_o}), 12'h007);
        chk(12'(igmp_to_switch_port_o), 12'h001);
        chk(12'({tag_mask_valid_o, tag_port_mask_o}), 12'h035);
        chk(12'(mirror_o), 12'h001);
        wr(8'h14, 8'h01);
        chk(12'(mirror_o), 12'h000);
        chk(12'({igmp_to_switch_port_o, tag_port_mask_o}), 12'h000);
        $display("test queue select done");
        @(posedge clk_i);
        vid_i <= 12'h000;
        port_vid_i <= 12'hABC;
        wr(8'h18, 8'hF8);
        chk(12'({back_pressure_o, half_duplex_o, flow_ctl_o, speed_10_o}),
            12'h00F);
        chk(vid_o, 12'hABC);
        wr(8'h18, 8'h00);
        chk(12'({back_pressure_o, half_duplex_o, flow_ctl_o, speed_10_o}),
            12'h000);
        chk(vid_o, 12'h000);
        $display("test switch port done");
        wr(8'h14, 8'h00);
        repeat (12) pick(1'b1, 1'b1, 2'h2);
        pick(1'b0, 1'b0, 2'h0);
        for (int c = 1; c < 4; c++) begin
            wr(8'h14, 8'(c << 2));
            pick(1'b0, 1'b1, 2'h1);
            repeat (ratio[c]) pick(1'b1, 1'b1, 2'h2);
            pick(1'b1, 1'b1, 2'h1);
        end
        $display("test scheduler done");
        wr(8'h1C, 8'h03);
        @(posedge clk_i);
        bcast_block_i <= 5'h03;
        port_is_10_i <= 5'h02;
        gap(0, n);
        chk(12'(n), 12'(PER));
        gap(1, n);
        chk(12'(n), 12'(PER * 10));
        wr(8'h18, 8'h01);
        repeat (PER * 20 + 5) @(negedge clk_i);
        chk(12'(storm_block_o), 12'h000);
        @(posedge clk_i);
        bcast_block_i <= 5'h00;
        $display("test storm done");
        pull_up <= 4'hF;
        do_reset();
        rd(8'h10, 8'hF2);
        rd(8'h18, 8'h70);
        chk(12'({half_duplex_o, flow_ctl_o, speed_10_o}), 12'h007);
        $display("test straps done");
        complete_run();
    end
endmodule
